// ==== rtl/pm_timer_pkg.sv ====
package pm_timer_pkg;

  // ***********************************************
  // register map, word aligned byte addresses
  // ***********************************************
  localparam logic [3:0] ADDR_COUNT = 4'h0;
  localparam logic [3:0] ADDR_CONTROL = 4'h4;
  localparam logic [3:0] ADDR_PERIOD = 4'h8;
  localparam logic [3:0] ADDR_IRQ = 4'hC;

  // ***********************************************
  // reset values
  // ***********************************************
  localparam logic [7:0] COUNT_RST = 8'h00;
  localparam logic [6:0] CONTROL_RST = 7'h00;
  localparam logic [7:0] PERIOD_RST = 8'hFF;

  // ***********************************************
  // control field positions
  // ***********************************************
  localparam int CTL_PRE_LSB = 0;
  localparam int CTL_ON_BIT = 2;
  localparam int CTL_POST_LSB = 3;

  // ***********************************************
  // irq register field positions
  // ***********************************************
  localparam int IRQ_FLAG_BIT = 0;
  localparam int IRQ_EN_BIT = 1;
  localparam int IRQ_PRIO_BIT = 2;

  // ***********************************************
  // prescaler terminal counts (divide minus one)
  // ***********************************************
  localparam logic [3:0] PRE_TC_1 = 4'h0;
  localparam logic [3:0] PRE_TC_4 = 4'h3;
  localparam logic [3:0] PRE_TC_16 = 4'hF;

endpackage

// ==== rtl/period_match_timer.sv ====
`timescale 1ns/1ps
// Overview of operation
// - the count input is the instruction clock, divided by 1, 4 or 16 as prescale_select is 00, 01 or 1x.
// - postscale_select in control bits 6 to 3 divides matches by its value plus one.
// - each count/period match advances a 4-bit postscaler whose overflow sets period_match_flag.
// - the count increments from zero and loads zero on the increment after it equals the period.
// - the period register is read/write and resets to FFh.
// - the count register is read/write and resets to zero.
// - writes to count or control, and reset, clear prescaler and postscaler.
// - a control write leaves the count value unchanged.
// - control bit 2 is timer_on; when low the timer stops incrementing.
// - all control bits reset to zero, the timer is off and bit 7 reads zero.
// - the pre-postscaler match pulse is output as a shift clock for the serial port.
// - the count and match pulse are output to the pwm unit as a time base.
module period_match_timer
(
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic CE,
  input wire logic INSTR_TICK,
  input wire logic [3:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [3:0] AVS_BYTEENABLE,
  input wire logic [31:0] AVS_WRITEDATA,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  output logic [1:0] AVS_RESPONSE,
  output logic [7:0] PWM_COUNT,
  output logic PWM_MATCH,
  output logic SSP_SHIFT_CLK,
  output logic IRQ_HIGH,
  output logic IRQ_LOW
);

  // ***********************************************
  // state
  // ***********************************************
  logic [7:0] count_q, count_d;
  logic [6:0] control_q, control_d;
  logic [7:0] period_q, period_d;
  logic [3:0] pre_q, pre_d;
  logic [3:0] post_q, post_d;
  logic flag_q, flag_d;
  logic irq_en_q, irq_en_d;
  logic irq_prio_q, irq_prio_d;
  logic match_q, match_d;
  logic ack_q, ack_d;
  logic [31:0] rdata_q, rdata_d;
  logic [1:0] resp_q, resp_d;

  logic req;
  logic wr_count, wr_control, wr_period, wr_irq;
  logic tick, inc, match_now, post_ovf;

  // terminal count of the prescaler for a select code
  function automatic logic [3:0] pre_tc(input logic [1:0] sel);
    if (sel[1])
      pre_tc = pm_timer_pkg::PRE_TC_16;
    else if (sel[0])
      pre_tc = pm_timer_pkg::PRE_TC_4;
    else
      pre_tc = pm_timer_pkg::PRE_TC_1;
  endfunction

  // ***********************************************
  // bus decode
  // ***********************************************
  // one wait cycle per access, so read data comes from a flop
  // writes land on the edge that completes the access, never earlier
  // frozen clock enable keeps the master stalled
  assign req = (AVS_READ | AVS_WRITE) & ~ack_q;
  assign wr_count = AVS_WRITE & ack_q & AVS_BYTEENABLE[0] & (AVS_ADDRESS == pm_timer_pkg::ADDR_COUNT);
  assign wr_control = AVS_WRITE & ack_q & AVS_BYTEENABLE[0] & (AVS_ADDRESS == pm_timer_pkg::ADDR_CONTROL);
  assign wr_period = AVS_WRITE & ack_q & AVS_BYTEENABLE[0] & (AVS_ADDRESS == pm_timer_pkg::ADDR_PERIOD);
  assign wr_irq = AVS_WRITE & ack_q & AVS_BYTEENABLE[0] & (AVS_ADDRESS == pm_timer_pkg::ADDR_IRQ);
  assign AVS_WAITREQUEST = (AVS_READ | AVS_WRITE) & ~(ack_q & CE);
  assign AVS_READDATA = rdata_q;
  assign AVS_RESPONSE = resp_q;

  // ***********************************************
  // counting datapath
  // ***********************************************
  // run gate
  assign tick = control_q[pm_timer_pkg::CTL_ON_BIT] & INSTR_TICK;
  assign inc = tick & (pre_q == pre_tc(control_q[pm_timer_pkg::CTL_PRE_LSB +: 2]));
  assign match_now = inc & (count_q == period_q);
  assign post_ovf = match_now & (post_q == control_q[pm_timer_pkg::CTL_POST_LSB +: 4]);

  // next state of timer and registers
  always_comb
  begin
    count_d = count_q;
    control_d = control_q;
    period_d = period_q;
    pre_d = pre_q;
    post_d = post_q;
    flag_d = flag_q;
    irq_en_d = irq_en_q;
    irq_prio_d = irq_prio_q;
    match_d = match_now;
    if (tick)
      pre_d = inc ? 4'h0 : pre_q + 4'h1;
    if (match_now)
    begin
      count_d = 8'h00;
      post_d = post_ovf ? 4'h0 : post_q + 4'h1;
    end
    else if (inc)
      count_d = count_q + 8'h01;
    if (wr_count)
    begin
      count_d = AVS_WRITEDATA[7:0];
      pre_d = 4'h0;
      post_d = 4'h0;
    end
    if (wr_control)
    begin
      control_d = AVS_WRITEDATA[6:0];
      pre_d = 4'h0;
      post_d = 4'h0;
    end
    if (wr_period)
      period_d = AVS_WRITEDATA[7:0];
    if (wr_irq)
    begin
      irq_en_d = AVS_WRITEDATA[pm_timer_pkg::IRQ_EN_BIT];
      irq_prio_d = AVS_WRITEDATA[pm_timer_pkg::IRQ_PRIO_BIT];
      if (AVS_WRITEDATA[pm_timer_pkg::IRQ_FLAG_BIT])
        flag_d = 1'b0;
    end
    if (post_ovf)
      flag_d = 1'b1;
  end

  // next state of bus answer
  always_comb
  begin
    ack_d = req;
    rdata_d = 32'h0000_0000;
    resp_d = 2'h0;
    if (req)
    begin
      case (AVS_ADDRESS)
        pm_timer_pkg::ADDR_COUNT: rdata_d = {24'h000000, count_q};
        pm_timer_pkg::ADDR_CONTROL: rdata_d = {25'h0000000, control_q};
        pm_timer_pkg::ADDR_PERIOD: rdata_d = {24'h000000, period_q};
        pm_timer_pkg::ADDR_IRQ: rdata_d = {29'h00000000, irq_prio_q, irq_en_q, flag_q};
        default: resp_d = 2'h3;
      endcase
      if (!AVS_READ)
        rdata_d = 32'h0000_0000;
    end
  end

  // registers
  always_ff @(posedge CLOCK)
  begin
    if (RST)
    begin
      count_q <= pm_timer_pkg::COUNT_RST;
      control_q <= pm_timer_pkg::CONTROL_RST;
      period_q <= pm_timer_pkg::PERIOD_RST;
      pre_q <= 4'h0;
      post_q <= 4'h0;
      flag_q <= 1'b0;
      irq_en_q <= 1'b0;
      irq_prio_q <= 1'b0;
      match_q <= 1'b0;
      ack_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      resp_q <= 2'h0;
    end
    else if (CE)
    begin
      count_q <= count_d;
      control_q <= control_d;
      period_q <= period_d;
      pre_q <= pre_d;
      post_q <= post_d;
      flag_q <= flag_d;
      irq_en_q <= irq_en_d;
      irq_prio_q <= irq_prio_d;
      match_q <= match_d;
      ack_q <= ack_d;
      rdata_q <= rdata_d;
      resp_q <= resp_d;
    end
  end

  // ***********************************************
  // outputs to neighbours
  // ***********************************************
  // pwm time base
  assign PWM_COUNT = count_q;
  assign PWM_MATCH = match_q;
  assign SSP_SHIFT_CLK = match_q;
  assign IRQ_HIGH = flag_q & irq_en_q & irq_prio_q;
  assign IRQ_LOW = flag_q & irq_en_q & ~irq_prio_q;

  // ***********************************************
  // checks
  // ***********************************************
  AST_WRAP: assert property (@(posedge CLOCK) disable iff (RST)
    CE && match_now && !wr_count |=> count_q == 8'h00)
    else $error("count did not wrap after match");
  AST_STOP_HOLD: assert property (@(posedge CLOCK) disable iff (RST)
    CE && !control_q[2] && !AVS_WRITE |=> $stable(count_q) && $stable(pre_q))
    else $error("timer moved while stopped");
  AST_CTL_KEEP: assert property (@(posedge CLOCK) disable iff (RST)
    CE && wr_control && !inc |=> count_q == $past(count_q) && pre_q == 4'h0 && post_q == 4'h0)
    else $error("control write disturbed count");
  AST_CNT_WR: assert property (@(posedge CLOCK) disable iff (RST)
    CE && wr_count |=> count_q == $past(AVS_WRITEDATA[7:0]) && pre_q == 4'h0)
    else $error("count write failed");
  AST_FLAG_SET: assert property (@(posedge CLOCK) disable iff (RST)
    CE && post_ovf |=> flag_q)
    else $error("flag not set on postscaler overflow");
  AST_STICKY: assert property (@(posedge CLOCK) disable iff (RST)
    flag_q && !(CE && wr_irq) |=> flag_q)
    else $error("flag dropped without clear");
  AST_MATCH_OUT: assert property (@(posedge CLOCK) disable iff (RST)
    CE && match_now |=> SSP_SHIFT_CLK && PWM_MATCH)
    else $error("match pulse missing");
  AST_PRE16: assert property (@(posedge CLOCK) disable iff (RST)
    inc |-> pre_q == pre_tc(control_q[1:0]) && control_q[2])
    else $error("increment off prescale terminal");
  AST_POST_RANGE: assert property (@(posedge CLOCK) disable iff (RST)
    post_q <= control_q[6:3] || $past(wr_count || wr_control) == 1'b0)
    else $error("postscaler past its limit");
  AST_RST_VAL: assert property (@(posedge CLOCK)
    $past(RST) |-> period_q == 8'hFF && count_q == 8'h00 && control_q == 7'h00)
    else $error("bad reset values");
  AST_PERIOD_WR: assert property (@(posedge CLOCK) disable iff (RST)
    CE && wr_period |=> period_q == $past(AVS_WRITEDATA[7:0]))
    else $error("period write failed");
  AST_CTL_WR: assert property (@(posedge CLOCK) disable iff (RST)
    CE && wr_control |=> control_q == $past(AVS_WRITEDATA[6:0]))
    else $error("control write failed");
  AST_CTL_CLR: assert property (@(posedge CLOCK) disable iff (RST)
    CE && wr_control |=> pre_q == 4'h0 && post_q == 4'h0)
    else $error("control write left scalers");
  AST_CNT_POST: assert property (@(posedge CLOCK) disable iff (RST)
    CE && wr_count |=> post_q == 4'h0)
    else $error("count write left postscaler");
  AST_RST_CLR: assert property (@(posedge CLOCK)
    $past(RST) |-> pre_q == 4'h0 && post_q == 4'h0 && !flag_q)
    else $error("scalers not cleared by reset");
  AST_INC_STEP: assert property (@(posedge CLOCK) disable iff (RST)
    CE && inc && !match_now && !wr_count |=> count_q == $past(count_q) + 8'h01)
    else $error("count did not step");
  AST_NO_TICK_HOLD: assert property (@(posedge CLOCK) disable iff (RST)
    CE && !inc && !wr_count |=> count_q == $past(count_q))
    else $error("count moved without increment");
  AST_POST_STEP: assert property (@(posedge CLOCK) disable iff (RST)
    CE && match_now && !post_ovf && !wr_count && !wr_control |=> post_q == $past(post_q) + 4'h1)
    else $error("postscaler did not step");
  AST_POST_WRAP: assert property (@(posedge CLOCK) disable iff (RST)
    CE && post_ovf && !wr_count && !wr_control |=> post_q == 4'h0)
    else $error("postscaler did not wrap");
  AST_MATCH_ONLY: assert property (@(posedge CLOCK) disable iff (RST)
    CE && !match_now |=> !SSP_SHIFT_CLK)
    else $error("shift clock without match");
  AST_IRQ_EXCL: assert property (@(posedge CLOCK) disable iff (RST)
    !(IRQ_HIGH && IRQ_LOW))
    else $error("both request levels raised");
  AST_CLEAR: assert property (@(posedge CLOCK) disable iff (RST)
    CE && wr_irq && AVS_WRITEDATA[0] && !post_ovf |=> !flag_q)
    else $error("flag clear failed");
  AST_STOP_POST: assert property (@(posedge CLOCK) disable iff (RST)
    CE && !control_q[pm_timer_pkg::CTL_ON_BIT] && !AVS_WRITE |=> $stable(post_q))
    else $error("postscaler moved while stopped");
  AST_NO_SET: assert property (@(posedge CLOCK) disable iff (RST)
    CE && !post_ovf && !flag_q |=> !flag_q)
    else $error("flag set without overflow");
  AST_TICK_GATE: assert property (@(posedge CLOCK) disable iff (RST)
    !tick |-> !inc)
    else $error("increment without tick");
  AST_PRE_HOLD: assert property (@(posedge CLOCK) disable iff (RST)
    CE && !tick && !wr_count && !wr_control |=> $stable(pre_q))
    else $error("prescaler moved without tick");
  AST_READ_ZERO: assert property (@(posedge CLOCK) disable iff (RST)
    CE && req && AVS_READ && AVS_ADDRESS == pm_timer_pkg::ADDR_CONTROL |=> AVS_READDATA[31:7] == 25'h0)
    else $error("control upper bits not zero");
  AST_CNT_READ: assert property (@(posedge CLOCK) disable iff (RST)
    CE && req && AVS_READ && AVS_ADDRESS == pm_timer_pkg::ADDR_COUNT |=> AVS_READDATA[7:0] == $past(count_q))
    else $error("count read wrong");

endmodule

// ==== verif/testbench.sv ====
`timescale 1ns/1ps
module testbench;
  logic CLOCK, RST, CE, INSTR_TICK, AVS_READ, AVS_WRITE, AVS_WAITREQUEST;
  logic PWM_MATCH, SSP_SHIFT_CLK, IRQ_HIGH, IRQ_LOW;
  logic [3:0] AVS_ADDRESS, AVS_BYTEENABLE;
  logic [31:0] AVS_WRITEDATA, AVS_READDATA, rd;
  logic [1:0] AVS_RESPONSE, resp, tick_div;
  logic [7:0] PWM_COUNT;
  int miscompares, compares, cycles, n, gap;
  logic [3:0] post_codes [3] = '{4'h0, 4'h2, 4'hF};

  period_match_timer dut (.CLOCK, .RST, .CE, .INSTR_TICK, .AVS_ADDRESS, .AVS_READ, .AVS_WRITE, .AVS_BYTEENABLE,
    .AVS_WRITEDATA, .AVS_READDATA, .AVS_WAITREQUEST, .AVS_RESPONSE, .PWM_COUNT, .PWM_MATCH, .SSP_SHIFT_CLK,
    .IRQ_HIGH, .IRQ_LOW);

  // ************************************************
  // clock, instruction tick and hang guard
  // ************************************************
  // 200 MHz system clock
  initial
  begin
    CLOCK = 1'b0;
    forever #2.5 CLOCK = ~CLOCK;
  end

  // one tick every fourth cycle, like an oscillator divided by four
  always @(posedge CLOCK)
  begin
    tick_div <= tick_div + 2'h1;
    INSTR_TICK <= (tick_div == 2'h3);
    cycles <= cycles + 1;
    if (cycles == 8000)
    begin
      miscompares++;
      give_verdict();
    end
  end

  // ************************************************
  // bus tasks and comparison
  // ************************************************
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp)
    begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  // request held until waitrequest is seen low, released after that edge
  task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d, input logic [3:0] be);
    @(posedge CLOCK);
    AVS_ADDRESS <= a;
    AVS_WRITEDATA <= {24'h0, d};
    AVS_BYTEENABLE <= be;
    AVS_WRITE <= wr;
    AVS_READ <= !wr;
    do @(posedge CLOCK); while (AVS_WAITREQUEST !== 1'b0);
    rd = AVS_READDATA;
    resp = AVS_RESPONSE;
    AVS_WRITE <= 1'b0;
    AVS_READ <= 1'b0;
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    bus(1'b1, a, d, 4'hF);
  endtask

  task automatic rdchk(input string what, input logic [3:0] a, input logic [31:0] exp);
    bus(1'b0, a, 8'h00, 4'hF);
    check(what, exp, rd);
  endtask

  // cycles between two match pulses; shift clock must follow the pulse
  task automatic match_gap(output int g);
    g = 0;
    do @(negedge CLOCK); while (PWM_MATCH !== 1'b1);
    check("shift clock", 32'h1, {31'h0, SSP_SHIFT_CLK});
    do begin @(negedge CLOCK); g++; end while (PWM_MATCH !== 1'b1);
  endtask

  task automatic give_verdict();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // ************************************************
  // main sequence
  // ************************************************
  initial
  begin
    {RST, CE} = 2'b11;
    {AVS_READ, AVS_WRITE, INSTR_TICK, tick_div} = '0;
    {AVS_ADDRESS, AVS_BYTEENABLE, AVS_WRITEDATA} = '0;
    {miscompares, compares, cycles} = '0;
    repeat (10) @(posedge CLOCK);
    RST <= 1'b0;
    // reset values and reserved bit
    rdchk("count", pm_timer_pkg::ADDR_COUNT, 32'h0);
    rdchk("control", pm_timer_pkg::ADDR_CONTROL, 32'h0);
    rdchk("period", pm_timer_pkg::ADDR_PERIOD, 32'hFF);
    wr(pm_timer_pkg::ADDR_CONTROL, 8'h80);
    rdchk("control bit7", pm_timer_pkg::ADDR_CONTROL, 32'h0);
    // lane 0 disabled write is dropped, then a real write lands
    bus(1'b1, pm_timer_pkg::ADDR_COUNT, 8'h33, 4'h0);
    rdchk("count lane off", pm_timer_pkg::ADDR_COUNT, 32'h0);
    wr(pm_timer_pkg::ADDR_COUNT, 8'h5A);
    rdchk("count", pm_timer_pkg::ADDR_COUNT, 32'h5A);
    check("pwm count", 32'h5A, {24'h0, PWM_COUNT});
    bus(1'b0, 4'h2, 8'h00, 4'hF);
    check("unmapped response", 32'h3, {30'h0, resp});
    check("unmapped data", 32'h0, rd);
    wr(pm_timer_pkg::ADDR_PERIOD, 8'h03);
    rdchk("period", pm_timer_pkg::ADDR_PERIOD, 32'h3);
    // every prescale code; four increments per match at period 3
    for (int p = 0; p < 4; p++)
    begin
      wr(pm_timer_pkg::ADDR_COUNT, 8'h00);
      wr(pm_timer_pkg::ADDR_CONTROL, 8'h04 | 8'(p));
      match_gap(gap);
      check("match interval", (p == 0) ? 32'd16 : (p == 1) ? 32'd64 : 32'd256, 32'(gap));
    end
    // matches counted up to the flag, a few extra cycles allowed
    foreach (post_codes[i])
    begin
      wr(pm_timer_pkg::ADDR_CONTROL, {1'b0, post_codes[i], 3'h0});
      wr(pm_timer_pkg::ADDR_IRQ, 8'h07);
      wr(pm_timer_pkg::ADDR_COUNT, 8'h00);
      wr(pm_timer_pkg::ADDR_CONTROL, {1'b0, post_codes[i], 3'h4});
      n = 0;
      do begin @(negedge CLOCK); n += PWM_MATCH; end while (IRQ_HIGH !== 1'b1);
      repeat (2) begin @(negedge CLOCK); n += PWM_MATCH; end
      check("matches per flag", 32'(post_codes[i]) + 32'h1, 32'(n));
      check("low request", 32'h0, {31'h0, IRQ_LOW});
    end
    // sticky flag, priority steering and enable gating
    wr(pm_timer_pkg::ADDR_CONTROL, 8'h00);
    wr(pm_timer_pkg::ADDR_IRQ, 8'h02);
    @(negedge CLOCK);
    check("low request", 32'h1, {31'h0, IRQ_LOW});
    check("high request", 32'h0, {31'h0, IRQ_HIGH});
    wr(pm_timer_pkg::ADDR_IRQ, 8'h00);
    @(negedge CLOCK);
    check("low request off", 32'h0, {31'h0, IRQ_LOW});
    rdchk("irq sticky", pm_timer_pkg::ADDR_IRQ, 32'h1);
    wr(pm_timer_pkg::ADDR_IRQ, 8'h01);
    rdchk("irq cleared", pm_timer_pkg::ADDR_IRQ, 32'h0);
    // control write keeps the count; stopped timer holds
    wr(pm_timer_pkg::ADDR_PERIOD, 8'hFF);
    wr(pm_timer_pkg::ADDR_COUNT, 8'h40);
    wr(pm_timer_pkg::ADDR_CONTROL, 8'h7B);
    rdchk("count kept", pm_timer_pkg::ADDR_COUNT, 32'h40);
    rdchk("control", pm_timer_pkg::ADDR_CONTROL, 32'h7B);
    repeat (60) @(posedge CLOCK);
    rdchk("count held", pm_timer_pkg::ADDR_COUNT, 32'h40);
    wr(pm_timer_pkg::ADDR_CONTROL, 8'h04);
    repeat (60) @(posedge CLOCK);
    wr(pm_timer_pkg::ADDR_CONTROL, 8'h00);
    bus(1'b0, pm_timer_pkg::ADDR_COUNT, 8'h00, 4'hF);
    check("count advanced", 32'h1, {31'h0, rd[7:0] > 8'h40});
    give_verdict();
  end
endmodule
